// ---- pkg/pms_defs.vh ----
// Constants of the power mode supervisor: register offsets, fields, resets
// Assumes inclusion by bare name from the design files
`ifndef PMS_DEFS_VH
`define PMS_DEFS_VH
// Register byte offsets
`define PMS_CTRL_OFS 8'h00
`define PMS_DET_OFS 8'h04
`define PMS_STAT_OFS 8'h08
`define PMS_FLAG_OFS 8'h0c
// Control register fields
`define PMS_CTRL_MODE_LSB 0
`define PMS_CTRL_MODE_MSB 2
`define PMS_CTRL_RANGE_BIT 3
`define PMS_CTRL_LPRUN_BIT 4
`define PMS_CTRL_WAKECLK_BIT 5
`define PMS_CTRL_RETAIN_BIT 6
`define PMS_CTRL_KERHSI_BIT 7
`define PMS_CTRL_RESET 8'h08
// Detector register fields
`define PMS_DET_EN_BIT 0
`define PMS_DET_FALL_BIT 1
`define PMS_DET_RISE_BIT 2
`define PMS_DET_LVL_LSB 3
`define PMS_DET_LVL_MSB 5
`define PMS_DET_RESET 6'h00
// Requested low-power mode codes
`define PMS_SEL_SLEEP 3'h0
`define PMS_SEL_STOP0 3'h1
`define PMS_SEL_STOP1 3'h2
`define PMS_SEL_STOP2 3'h3
`define PMS_SEL_STANDBY 3'h4
`define PMS_SEL_SHUTDOWN 3'h5
// Brownout level code at power on (lowest, 1.71 V)
`define PMS_BOR_LVL_RESET 3'h0
// Wakeup clock codes: multispeed oscillator frequency select
`define PMS_MSI_4MHZ 4'h6
`define PMS_MSI_8MHZ 4'h7
`define PMS_MSI_48MHZ 4'hb
`endif

// ---- rtl/pms_sync.v ----
// Two-flop synchroniser for a bundle of pin levels
// Assumes the inputs are asynchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module pms_sync #(
  parameter WIDTH = 4
) (
  input wire clk_in,
  input wire nrst_in,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage;
  // First stage feeds only the second
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      stage <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage <= async_in;
      sync_out <= stage;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pms_ahb.v ----
// AHB-Lite slave front end: registers the address phase, gives write strobe
// Assumes single word transfers; always zero wait states, OKAY response
`timescale 1ns/1ps
`default_nettype none
module pms_ahb (
  input wire clk_in,
  input wire nrst_in,
  input wire hsel_in,
  input wire [7:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire hready_in,
  output reg wr_out,
  output reg [7:0] addr_out
);
  // Capture valid address phases
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      wr_out <= 1'b0;
      addr_out <= 8'h00;
    end else if (hready_in) begin
      wr_out <= hsel_in & htrans_in[1] & hwrite_in;
      addr_out <= haddr_in;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pms_top.v ----
// Power mode supervisor: brownout hold, supply detectors, regulator choice
// and low-power mode sequencing, with AHB-Lite registers.
// Assumes comparator and wait/wake levels come from outside the clock domain.
//
// Functional notes
// - Hold reset while supply below brownout level
// - Brownout active everywhere except shutdown
// - Brownout level defaults lowest, options raise it
// - Drop detector interrupts on fall, rise, both
// - Analog supply monitor reports functional range
// - Main regulator in run, sleep, stop 0
// - Low-power regulator in LP modes, retention
// - Both regulators off in shutdown, and in standby without retention
// - Low-power run: low-power regulator, main off
// - Low-power run kernels may use 16 MHz
// - Any reset returns to run mode
// - Sleep stops only processor clock
// - Low-power sleep only from low-power run
// - Stop gates core clocks, fast oscillators
// - Wakeup peripheral may request 16 MHz in stop
// - Stop 0 keeps main; stop 2 low leakage
// - Stop exit clock multispeed or 16 MHz
// - Standby wake restarts multispeed at 8 MHz
// - Shutdown wake restarts multispeed at 4 MHz
`timescale 1ns/1ps
`default_nettype none
`include "pms_defs.vh"
module pms_top (
  input wire CLOCK_IN,
  input wire NRST_IN,
  input wire HSEL_IN,
  input wire [7:0] HADDR_IN,
  input wire [1:0] HTRANS_IN,
  input wire HWRITE_IN,
  input wire [2:0] HSIZE_IN,
  input wire HREADY_IN,
  input wire [31:0] HWDATA_IN,
  input wire [2:0] BOR_OPTION_IN,
  input wire SUPPLY_BELOW_BOR_IN,
  input wire SUPPLY_BELOW_DROP_IN,
  input wire ANALOG_SUPPLY_OK_IN,
  input wire WAIT_INSTR_IN,
  input wire WAKE_EVENT_IN,
  input wire WAKEUP_HSI_REQ_IN,
  output reg [31:0] HRDATA_OUT,
  output reg HREADYOUT_OUT,
  output reg HRESP_OUT,
  output reg BROWNOUT_RESET_OUT,
  output reg SUPPLY_DROP_IRQ_OUT,
  output reg MAIN_REGULATOR_EN_OUT,
  output reg LOW_POWER_REGULATOR_EN_OUT,
  output reg RETAINED_RAM_POWER_OUT,
  output reg CORE_LOW_LEAKAGE_OUT,
  output reg CPU_CLOCK_EN_OUT,
  output reg CORE_CLOCK_EN_OUT,
  output reg PLL_EN_OUT,
  output reg MULTISPEED_OSC_EN_OUT,
  output reg [3:0] MULTISPEED_FREQ_OUT,
  output reg INTERNAL_16MHZ_OSC_EN_OUT,
  output reg KERNEL_CLK_16MHZ_SEL_OUT,
  output reg SYSCLK_16MHZ_SEL_OUT,
  output reg SLOW_OSC_EN_OUT,
  output reg [2:0] DROP_LEVEL_OUT,
  output reg [2:0] BOR_LEVEL_OUT,
  output reg CLOCK_LIMIT_26MHZ_OUT,
  output reg CLOCK_LIMIT_2MHZ_OUT
);
  // ==========================================================
  // Mode states
  localparam ST_RUN = 4'h0;
  localparam ST_SLEEP = 4'h1;
  localparam ST_LPRUN = 4'h2;
  localparam ST_LPSLEEP = 4'h3;
  localparam ST_STOP0 = 4'h4;
  localparam ST_STOP1 = 4'h5;
  localparam ST_STOP2 = 4'h6;
  localparam ST_STANDBY = 4'h7;
  localparam ST_SHUTDOWN = 4'h8;

  // ==========================================================
  // Pin synchronisation
  wire [5:0] pins;
  pms_sync #(.WIDTH(6)) u_sync (
    .clk_in(CLOCK_IN),
    .nrst_in(NRST_IN),
    .async_in({SUPPLY_BELOW_BOR_IN, SUPPLY_BELOW_DROP_IN,
      ANALOG_SUPPLY_OK_IN, WAIT_INSTR_IN, WAKE_EVENT_IN,
      WAKEUP_HSI_REQ_IN}),
    .sync_out(pins)
  );
  wire below_bor = pins[5];
  wire below_drop = pins[4];
  wire analog_ok = pins[3];
  wire wait_instr = pins[2];
  wire wake = pins[1];
  wire hsi_req = pins[0];

  // ==========================================================
  // Bus front end
  wire bus_wr;
  wire [7:0] bus_addr;
  pms_ahb u_ahb (
    .clk_in(CLOCK_IN),
    .nrst_in(NRST_IN),
    .hsel_in(HSEL_IN),
    .haddr_in(HADDR_IN),
    .htrans_in(HTRANS_IN),
    .hwrite_in(HWRITE_IN),
    .hready_in(HREADY_IN),
    .wr_out(bus_wr),
    .addr_out(bus_addr)
  );

  // Address decode, used for writes and reads
  function is_reg;
    input [7:0] a;
    input [7:0] ofs;
    begin
      is_reg = (a[7:2] == ofs[7:2]);
    end
  endfunction

  // ==========================================================
  // Registers
  reg [7:0] ctrl;
  reg [5:0] det;
  reg drop_flag;
  reg drop_prev;
  reg [3:0] state;
  reg [3:0] next_state;
  reg bor_latched;
  reg bor_taken;
  reg [2:0] last_mode;

  wire [2:0] sel_mode = ctrl[`PMS_CTRL_MODE_MSB:`PMS_CTRL_MODE_LSB];
  wire det_en = det[`PMS_DET_EN_BIT];
  wire in_stop = (state == ST_STOP0) | (state == ST_STOP1) |
    (state == ST_STOP2);
  wire bor_live = (state != ST_SHUTDOWN);
  wire bor_hold = bor_live & below_bor;

  // Drop detector edges and sticky flag
  wire fall_ev = det_en & below_drop & ~drop_prev;
  wire rise_ev = det_en & ~below_drop & drop_prev;
  wire drop_set = (fall_ev & det[`PMS_DET_FALL_BIT]) |
    (rise_ev & det[`PMS_DET_RISE_BIT]);
  wire drop_clr = bus_wr & is_reg(bus_addr, `PMS_FLAG_OFS) & HWDATA_IN[0];

  // Register writes, flag and brownout level capture
  always @(posedge CLOCK_IN) begin
    if (!NRST_IN) begin
      ctrl <= `PMS_CTRL_RESET;
      det <= `PMS_DET_RESET;
      drop_flag <= 1'b0;
      drop_prev <= 1'b0;
      bor_taken <= 1'b0;
      BOR_LEVEL_OUT <= `PMS_BOR_LVL_RESET;
    end else begin
      drop_prev <= below_drop;
      if (!bor_taken) begin
        BOR_LEVEL_OUT <= BOR_OPTION_IN;
        bor_taken <= 1'b1;
      end
      if (bus_wr & is_reg(bus_addr, `PMS_CTRL_OFS))
        ctrl <= HWDATA_IN[7:0];
      if (bus_wr & is_reg(bus_addr, `PMS_DET_OFS))
        det <= HWDATA_IN[5:0];
      // Set wins over clear
      if (drop_set)
        drop_flag <= 1'b1;
      else if (drop_clr)
        drop_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Mode sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_RUN, ST_LPRUN: begin
        if (state == ST_RUN && ctrl[`PMS_CTRL_LPRUN_BIT])
          next_state = ST_LPRUN;
        else if (state == ST_LPRUN && !ctrl[`PMS_CTRL_LPRUN_BIT])
          next_state = ST_RUN;
        else if (wait_instr) begin
          case (sel_mode)
            `PMS_SEL_SLEEP:
              next_state = (state == ST_LPRUN) ? ST_LPSLEEP : ST_SLEEP;
            `PMS_SEL_STOP0: next_state = ST_STOP0;
            `PMS_SEL_STOP1: next_state = ST_STOP1;
            `PMS_SEL_STOP2: next_state = ST_STOP2;
            `PMS_SEL_STANDBY: next_state = ST_STANDBY;
            `PMS_SEL_SHUTDOWN: next_state = ST_SHUTDOWN;
            default: next_state = state;
          endcase
        end
      end
      ST_SLEEP: if (wake) next_state = ST_RUN;
      ST_LPSLEEP: if (wake) next_state = ST_LPRUN;
      ST_STOP0, ST_STOP1, ST_STOP2: if (wake) next_state = ST_RUN;
      ST_STANDBY, ST_SHUTDOWN: if (wake) next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  // State register; brownout forces run while held
  always @(posedge CLOCK_IN) begin
    if (!NRST_IN) begin
      state <= ST_RUN;
      bor_latched <= 1'b0;
      last_mode <= 3'h0;
    end else if (bor_hold) begin
      state <= ST_RUN;
      bor_latched <= 1'b1;
    end else begin
      state <= next_state;
      bor_latched <= 1'b0;
      if (next_state != state)
        last_mode <= (state == ST_STANDBY) ? 3'h2 :
          (state == ST_SHUTDOWN) ? 3'h3 : in_stop ? 3'h1 : 3'h0;
    end
  end

  // ==========================================================
  // Registered outputs
  always @(posedge CLOCK_IN) begin
    if (!NRST_IN) begin
      BROWNOUT_RESET_OUT <= 1'b1;
      SUPPLY_DROP_IRQ_OUT <= 1'b0;
      MAIN_REGULATOR_EN_OUT <= 1'b1;
      LOW_POWER_REGULATOR_EN_OUT <= 1'b0;
      RETAINED_RAM_POWER_OUT <= 1'b1;
      CORE_LOW_LEAKAGE_OUT <= 1'b0;
      CPU_CLOCK_EN_OUT <= 1'b1;
      CORE_CLOCK_EN_OUT <= 1'b1;
      PLL_EN_OUT <= 1'b0;
      MULTISPEED_OSC_EN_OUT <= 1'b1;
      MULTISPEED_FREQ_OUT <= `PMS_MSI_4MHZ;
      INTERNAL_16MHZ_OSC_EN_OUT <= 1'b0;
      KERNEL_CLK_16MHZ_SEL_OUT <= 1'b0;
      SYSCLK_16MHZ_SEL_OUT <= 1'b0;
      SLOW_OSC_EN_OUT <= 1'b1;
      DROP_LEVEL_OUT <= 3'h0;
      CLOCK_LIMIT_26MHZ_OUT <= 1'b1;
      CLOCK_LIMIT_2MHZ_OUT <= 1'b0;
    end else begin
      BROWNOUT_RESET_OUT <= bor_hold;
      SUPPLY_DROP_IRQ_OUT <= drop_flag;
      MAIN_REGULATOR_EN_OUT <= (state == ST_RUN) | (state == ST_SLEEP) |
        (state == ST_STOP0);
      LOW_POWER_REGULATOR_EN_OUT <= (state == ST_LPRUN) |
        (state == ST_LPSLEEP) | (state == ST_STOP1) | (state == ST_STOP2) |
        ((state == ST_STANDBY) & ctrl[`PMS_CTRL_RETAIN_BIT]);
      RETAINED_RAM_POWER_OUT <= (state != ST_SHUTDOWN) &
        ((state != ST_STANDBY) | ctrl[`PMS_CTRL_RETAIN_BIT]);
      CORE_LOW_LEAKAGE_OUT <= (state == ST_STOP2);
      CPU_CLOCK_EN_OUT <= (state == ST_RUN) | (state == ST_LPRUN);
      CORE_CLOCK_EN_OUT <= (state == ST_RUN) | (state == ST_LPRUN) |
        (state == ST_SLEEP) | (state == ST_LPSLEEP);
      PLL_EN_OUT <= ((state == ST_RUN) | (state == ST_SLEEP)) &
        ~ctrl[`PMS_CTRL_RANGE_BIT];
      MULTISPEED_OSC_EN_OUT <= ~in_stop & (state != ST_STANDBY) &
        (state != ST_SHUTDOWN);
      // Wakeup clock choice by mode left
      case (last_mode)
        3'h2: MULTISPEED_FREQ_OUT <= `PMS_MSI_8MHZ;
        3'h3: MULTISPEED_FREQ_OUT <= `PMS_MSI_4MHZ;
        3'h1: MULTISPEED_FREQ_OUT <= `PMS_MSI_48MHZ;
        default: MULTISPEED_FREQ_OUT <= MULTISPEED_FREQ_OUT;
      endcase
      SYSCLK_16MHZ_SEL_OUT <= (last_mode == 3'h1) &
        ctrl[`PMS_CTRL_WAKECLK_BIT];
      INTERNAL_16MHZ_OSC_EN_OUT <= in_stop ? hsi_req :
        (SYSCLK_16MHZ_SEL_OUT | ctrl[`PMS_CTRL_KERHSI_BIT]) &
        (state != ST_STANDBY) & (state != ST_SHUTDOWN);
      KERNEL_CLK_16MHZ_SEL_OUT <= ctrl[`PMS_CTRL_KERHSI_BIT] &
        ((state == ST_LPRUN) | (state == ST_LPSLEEP));
      SLOW_OSC_EN_OUT <= (state != ST_SHUTDOWN);
      DROP_LEVEL_OUT <= det[`PMS_DET_LVL_MSB:`PMS_DET_LVL_LSB];
      CLOCK_LIMIT_26MHZ_OUT <= ctrl[`PMS_CTRL_RANGE_BIT];
      CLOCK_LIMIT_2MHZ_OUT <= (state == ST_LPRUN) |
        (state == ST_LPSLEEP);
    end
  end

  // ==========================================================
  // Read data and response, zero wait states
  always @(posedge CLOCK_IN) begin
    if (!NRST_IN) begin
      HRDATA_OUT <= 32'h00000000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end else begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
      if (HREADY_IN & HSEL_IN & HTRANS_IN[1] & ~HWRITE_IN) begin
        if (is_reg(HADDR_IN, `PMS_CTRL_OFS))
          HRDATA_OUT <= {24'h000000, ctrl};
        else if (is_reg(HADDR_IN, `PMS_DET_OFS))
          HRDATA_OUT <= {26'h0000000, det};
        else if (is_reg(HADDR_IN, `PMS_STAT_OFS))
          HRDATA_OUT <= {22'h000000, analog_ok, below_drop, bor_latched,
            BOR_LEVEL_OUT, state};
        else if (is_reg(HADDR_IN, `PMS_FLAG_OFS))
          HRDATA_OUT <= {31'h00000000, drop_flag};
        else
          HRDATA_OUT <= 32'h00000000;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/pms_top_properties.sv ----
// Concurrent checks on the ports of the power mode supervisor top
// Assumes binding onto pms_top; one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "pms_defs.vh"
module pms_top_props (
  input wire logic CLOCK_IN,
  input wire logic NRST_IN,
  input wire logic [7:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic WAIT_INSTR_IN,
  input wire logic SUPPLY_BELOW_BOR_IN,
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  input wire logic BROWNOUT_RESET_OUT,
  input wire logic SUPPLY_DROP_IRQ_OUT,
  input wire logic MAIN_REGULATOR_EN_OUT,
  input wire logic LOW_POWER_REGULATOR_EN_OUT,
  input wire logic CORE_LOW_LEAKAGE_OUT,
  input wire logic CPU_CLOCK_EN_OUT,
  input wire logic CORE_CLOCK_EN_OUT,
  input wire logic PLL_EN_OUT,
  input wire logic MULTISPEED_OSC_EN_OUT,
  input wire logic CLOCK_LIMIT_2MHZ_OUT
);
  // ==========================================
  // History of flag writes and wait requests
  logic [3:0] fw_h;
  logic [7:0] wait_h;
  wire fw = HTRANS_IN[1] && HWRITE_IN && HADDR_IN == `PMS_FLAG_OFS;
  always_ff @(posedge CLOCK_IN) begin
    fw_h <= {fw_h[2:0], fw};
    wait_h <= {wait_h[6:0], WAIT_INSTR_IN};
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!NRST_IN);
  sequence s_bor_low; SUPPLY_BELOW_BOR_IN [*6]; endsequence
  sequence s_wait_seen; wait_h != 8'h00; endsequence
  a_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT)
    else $error("bus answer not ready or not okay");
  a_bor_hold: assert property (s_bor_low |-> BROWNOUT_RESET_OUT ||
    !(MAIN_REGULATOR_EN_OUT || LOW_POWER_REGULATOR_EN_OUT))
    else $error("low supply without brownout hold");
  a_run_supply: assert property (CORE_CLOCK_EN_OUT |->
    MAIN_REGULATOR_EN_OUT != LOW_POWER_REGULATOR_EN_OUT)
    else $error("running core without exactly one regulator");
  a_stop_gate: assert property (!CORE_CLOCK_EN_OUT |->
    !PLL_EN_OUT && !MULTISPEED_OSC_EN_OUT)
    else $error("fast clocks left on with core clocks stopped");
  a_leak_stop2: assert property (CORE_LOW_LEAKAGE_OUT |->
    !CORE_CLOCK_EN_OUT && !MAIN_REGULATOR_EN_OUT)
    else $error("low leakage outside deep stop");
  a_lprun_limit: assert property (CPU_CLOCK_EN_OUT &&
    LOW_POWER_REGULATOR_EN_OUT |-> CLOCK_LIMIT_2MHZ_OUT)
    else $error("low-power run without 2 MHz limit");
  a_wait_entry: assert property ($fell(CPU_CLOCK_EN_OUT) |-> s_wait_seen)
    else $error("processor clock stopped without wait request");
  a_drop_sticky: assert property ($fell(SUPPLY_DROP_IRQ_OUT) |->
    fw_h != 4'h0)
    else $error("drop flag cleared without a flag write");
endmodule
bind pms_top pms_top_props u_props (.CLOCK_IN(CLOCK_IN), .NRST_IN(NRST_IN),
  .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
  .WAIT_INSTR_IN(WAIT_INSTR_IN), .SUPPLY_BELOW_BOR_IN(SUPPLY_BELOW_BOR_IN),
  .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
  .BROWNOUT_RESET_OUT(BROWNOUT_RESET_OUT),
  .SUPPLY_DROP_IRQ_OUT(SUPPLY_DROP_IRQ_OUT),
  .MAIN_REGULATOR_EN_OUT(MAIN_REGULATOR_EN_OUT),
  .LOW_POWER_REGULATOR_EN_OUT(LOW_POWER_REGULATOR_EN_OUT),
  .CORE_LOW_LEAKAGE_OUT(CORE_LOW_LEAKAGE_OUT),
  .CPU_CLOCK_EN_OUT(CPU_CLOCK_EN_OUT), .CORE_CLOCK_EN_OUT(CORE_CLOCK_EN_OUT),
  .PLL_EN_OUT(PLL_EN_OUT), .MULTISPEED_OSC_EN_OUT(MULTISPEED_OSC_EN_OUT),
  .CLOCK_LIMIT_2MHZ_OUT(CLOCK_LIMIT_2MHZ_OUT));
`default_nettype wire

// ---- dv/pms_top_bench.sv ----
// Self-checking bench of the power mode supervisor top
// Assumes the checker is bound separately; bench is the bus master
`timescale 1ns/1ps
`default_nettype none
`include "pms_defs.vh"
module pms_top_bench;
  logic clk, nrst = 1'b0, hsel = 1'b0, hw = 1'b0, bor = 1'b0, drop = 1'b0;
  logic aok = 1'b1, wi = 1'b0, wk = 1'b0, hreq = 1'b0;
  logic [7:0] ha = 8'h00;
  logic [1:0] ht = 2'h0;
  logic [31:0] hwd = 32'h0, r;
  wire [31:0] hrd;
  wire hro, hresp, brst, irq, mreg, low_power_regulator, ram, leak, cpu, core, pll, multispeed_oscillator;
  wire hsi, ksel, ssel, slow, l26, l2;
  wire [3:0] mf;
  wire [2:0] dl, bl;
  int bad_count = 0, compares = 0;
  pms_top u_dut (.CLOCK_IN(clk), .NRST_IN(nrst), .HSEL_IN(hsel),
    .HADDR_IN(ha), .HTRANS_IN(ht), .HWRITE_IN(hw), .HSIZE_IN(3'h2),
    .HREADY_IN(hro), .HWDATA_IN(hwd), .BOR_OPTION_IN(3'h2),
    .SUPPLY_BELOW_BOR_IN(bor), .SUPPLY_BELOW_DROP_IN(drop),
    .ANALOG_SUPPLY_OK_IN(aok), .WAIT_INSTR_IN(wi), .WAKE_EVENT_IN(wk),
    .WAKEUP_HSI_REQ_IN(hreq), .HRDATA_OUT(hrd), .HREADYOUT_OUT(hro),
    .HRESP_OUT(hresp), .BROWNOUT_RESET_OUT(brst), .SUPPLY_DROP_IRQ_OUT(irq),
    .MAIN_REGULATOR_EN_OUT(mreg), .LOW_POWER_REGULATOR_EN_OUT(low_power_regulator),
    .RETAINED_RAM_POWER_OUT(ram), .CORE_LOW_LEAKAGE_OUT(leak),
    .CPU_CLOCK_EN_OUT(cpu), .CORE_CLOCK_EN_OUT(core), .PLL_EN_OUT(pll),
    .MULTISPEED_OSC_EN_OUT(multispeed_oscillator), .MULTISPEED_FREQ_OUT(mf),
    .INTERNAL_16MHZ_OSC_EN_OUT(hsi), .KERNEL_CLK_16MHZ_SEL_OUT(ksel),
    .SYSCLK_16MHZ_SEL_OUT(ssel), .SLOW_OSC_EN_OUT(slow),
    .DROP_LEVEL_OUT(dl), .BOR_LEVEL_OUT(bl), .CLOCK_LIMIT_26MHZ_OUT(l26),
    .CLOCK_LIMIT_2MHZ_OUT(l2));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================
  // Shared tasks: compare, verdict, bus, pins
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hro !== 1'b1) begin
      n++;
      if (n > 50) begin
        $display("mismatch at %0t: bus wait timed out", $time);
        bad_count++;
        report_and_stop();
      end
      @(posedge clk);
    end
  endtask
  // One single-word transfer; read data lands in r
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    ht <= 2'h2;
    ha <= a;
    hw <= w;
    wait_rdy();
    hsel <= 1'b0;
    ht <= 2'h0;
    hwd <= d;
    wait_rdy();
    r = hrd;
  endtask
  task settle;
    repeat (8) @(posedge clk);
  endtask
  task pulse(input bit wake);
    if (wake) wk <= 1'b1;
    else wi <= 1'b1;
    settle();
    wk <= 1'b0;
    wi <= 1'b0;
    settle();
  endtask
  task do_reset;
    nrst <= 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
  endtask
  // ==========================================
  // Scenarios
  task t_after_reset;
    xfer(0, `PMS_CTRL_OFS, 0);
    chk(r, `PMS_CTRL_RESET);
    xfer(0, `PMS_STAT_OFS, 0);
    chk(r, 32'h220);
    chk(bl, 3'h2);
    xfer(0, 8'h10, 0);
    chk(r, 0);
    chk(hresp, 0);
  endtask
  task t_modes;
    for (int m = 0; m < 6; m++) begin
      xfer(1, `PMS_CTRL_OFS, 32'h48 | m | (m == 2 ? 32'h20 : 0));
      settle();
      chk(cpu, 1);
      pulse(0);
      xfer(0, `PMS_STAT_OFS, 0);
      chk(r[3:0], m == 0 ? 1 : m + 3);
      chk({mreg, cpu, core, leak}, {m < 2, 1'b0, m == 0, m == 3});
      chk(low_power_regulator, m > 1 && m < 5);
      if (m == 4) chk(ram, 1);
      if (m > 0 && m < 4) begin
        chk({pll, multispeed_oscillator, slow}, 3'b001);
        hreq <= 1'b1;
        settle();
        chk(hsi, 1);
        hreq <= 1'b0;
      end
      if (m == 5) begin
        bor <= 1'b1;
        settle();
        chk(brst, 0);
        bor <= 1'b0;
      end
      pulse(1);
      xfer(0, `PMS_STAT_OFS, 0);
      chk(r[3:0], 0);
      if (m == 4) chk(mf, `PMS_MSI_8MHZ);
      if (m == 5) chk(mf, `PMS_MSI_4MHZ);
      if (m > 0 && m < 4) chk(ssel, m == 2);
      if (m > 0 && m < 4) chk(mf, `PMS_MSI_48MHZ);
    end
  endtask
  task t_lprun;
    xfer(1, `PMS_CTRL_OFS, 32'h98);
    settle();
    chk({mreg, low_power_regulator, l2, ksel}, 4'b0111);
    pulse(0);
    xfer(0, `PMS_STAT_OFS, 0);
    chk({r[3:0], cpu, core, low_power_regulator}, 7'h1b);
    pulse(1);
    xfer(0, `PMS_STAT_OFS, 0);
    chk(r[3:0], 2);
    xfer(1, `PMS_CTRL_OFS, 32'h00);
    settle();
    chk({l26, mreg}, 2'b01);
    xfer(1, `PMS_CTRL_OFS, 32'h08);
    settle();
    chk(l26, 1);
  endtask
  task t_brownout;
    xfer(1, `PMS_CTRL_OFS, 32'h0a);
    pulse(0);
    bor <= 1'b1;
    settle();
    chk(brst, 1);
    xfer(0, `PMS_STAT_OFS, 0);
    chk({r[7], r[3:0]}, 5'h10);
    bor <= 1'b0;
    settle();
    chk(brst, 0);
  endtask
  task t_drop;
    drop <= 1'b1;
    settle();
    chk(irq, 0);
    drop <= 1'b0;
    xfer(1, `PMS_DET_OFS, 32'h1b);
    settle();
    chk(dl, 3);
    drop <= 1'b1;
    settle();
    xfer(0, `PMS_STAT_OFS, 0);
    chk({irq, r[8]}, 2'b11);
    drop <= 1'b0;
    settle();
    chk(irq, 1);
    xfer(1, `PMS_FLAG_OFS, 1);
    settle();
    chk(irq, 0);
    xfer(1, `PMS_DET_OFS, 32'h05);
    drop <= 1'b1;
    settle();
    chk(irq, 0);
    drop <= 1'b0;
    settle();
    chk(irq, 1);
    aok <= 1'b0;
    settle();
    xfer(0, `PMS_STAT_OFS, 0);
    chk(r[9], 0);
  endtask
  // Main sequence, ending with a reset taken from stop
  initial begin
    @(posedge clk);
    do_reset();
    t_after_reset();
    t_modes();
    t_lprun();
    t_brownout();
    t_drop();
    xfer(1, `PMS_CTRL_OFS, 32'h0a);
    pulse(0);
    do_reset();
    xfer(0, `PMS_STAT_OFS, 0);
    chk(r[3:0], 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
